// File: hdl/sus_core.sv
// Serial shift unit: shift register, edge counter, flags and register port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Start detector is active only in the two-wire modes.
// - Start detector works without the system clock and can wake from power-down.
// - External clock pin increments the counter on both edges.
// - Counter preset to 15 overflows on the next external edge: extra edge interrupt.
// - Data write in the same cycle as a shift clock wins; no shift.
// - Shift left, input into bit 0, clocked by pin, timer match or strobe.
// - Data output pin follows bit 7 through an output latch.
// - Latch open first half of serial clock if external, always if internal.
// - Open latch shows a new bit 7 at once; sample and change on opposite edges.
// - Shift register is copied to the buffer when a transfer completes.
// - Start flag set by start condition, or any clock-pin edge in other modes with an external source and strobe bit clear.
// - Start flag clears only on write of one; clearing releases the SCL hold.
// - Start interrupt when flag, its enable and global enable are set; wakes all.
// - Overflow flag set on wrap 15 to 0; interrupt with its enables.
// - Overflow flag clears only on write of one; clearing releases the SCL hold.
// - Overflow interrupt wakes from idle sleep only.
// - Stop flag set on stop condition in two-wire mode; never interrupts.
// - Collision bit reads one when bit 7 differs from the data pin.
// - Counter readable and writable; counts pin, timer or strobe clocks.
// - External source with clock strobe bit set: clocked by toggle strobe writes.
// - Start interrupt enable is control bit 7; pending request taken at once.
// - Second two-wire mode also holds SCL low on overflow until flag cleared.
// - Software strobe source: strobe bit write clocks shift register and counter once.
module sus_core
    import sus_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire sus_bus_req_type bus_req,
    output logic [DATA_W-1:0] rdata,
    // Serial pins
    input wire logic serial_data_in,
    input wire logic serial_clock_pin,
    output sus_pin_out_type pins,
    // Port direction bits and clock source from the core
    input wire logic data_dir_out,
    input wire logic clock_dir_out,
    input wire logic timer_match,
    // Interrupt and sleep context
    input wire logic global_int_enable,
    input wire logic sleep_is_idle,
    output logic start_irq,
    output logic overflow_irq,
    output logic overflow_wake,
    output logic start_wake
);
    typedef struct packed {
        logic [DATA_W-1:0] shift_data_bits;
        logic [DATA_W-1:0] received_byte_buffer;
        logic [CNT_W-1:0] edge_counter_value;
        logic start_flag;
        logic overflow_flag;
        logic stop_flag;
        logic start_interrupt_enable;
        logic overflow_interrupt_enable;
        logic [1:0] wire_mode_select;
        logic [1:0] clock_source_select;
        logic clock_strobe_bit;
        logic clock_port;
        logic out_latch;
        logic sck_prev;
        logic sdi_prev;
        logic det_prev;
        logic det_clear;
        logic det_enable;
        logic hold_start;
        logic hold_ovf;
        logic start_irq;
        logic overflow_irq;
        logic overflow_wake;
        sus_pin_out_type pins;
        logic [DATA_W-1:0] rdata;
    } sus_state_type;

    sus_state_type st;
    sus_state_type next_st;

    logic sdi_s;
    logic sck_s;
    logic det_s;
    logic det_raw;
    logic wr_data;
    logic wr_status;
    logic wr_ctrl;
    logic two_wire;
    logic ext_src;
    logic ext_rise;
    logic ext_fall;
    logic ext_edge;
    logic sw_strobe;
    logic tc_strobe;
    logic shift_clk;
    logic cnt_clk;
    logic ovf_event;
    logic latch_open;
    logic collision;
    logic [DATA_W-1:0] shifted;
    logic [CNT_W-1:0] cnt_plus;

    function automatic logic [DATA_W-1:0] status_word(input sus_state_type s, input logic coll);
        status_word = {s.start_flag, s.overflow_flag, s.stop_flag, coll, s.edge_counter_value};
    endfunction

    function automatic logic [DATA_W-1:0] control_word(input sus_state_type s);
        // Strobe bits read back as zero
        control_word = {s.start_interrupt_enable, s.overflow_interrupt_enable, s.wire_mode_select,
                        s.clock_source_select, 1'b0, 1'b0};
    endfunction

    sus_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({serial_data_in, serial_clock_pin, det_raw}),
        .sync_out({sdi_s, sck_s, det_s})
    );

    sus_start_detect u_start (
        .reset(reset),
        .enable(st.det_enable),
        .clear(st.det_clear),
        .sda_in(serial_data_in),
        .scl_in(serial_clock_pin),
        .detected(det_raw)
    );

    always_comb begin
        next_st = st;
        wr_data = bus_req.wr && (bus_req.addr == OFF_SHIFT_DATA);
        wr_status = bus_req.wr && (bus_req.addr == OFF_STATUS);
        wr_ctrl = bus_req.wr && (bus_req.addr == OFF_CONTROL);
        two_wire = st.wire_mode_select[1];
        ext_src = st.clock_source_select[1];
        ext_rise = sck_s && !st.sck_prev;
        ext_fall = !sck_s && st.sck_prev;
        ext_edge = ext_rise || ext_fall;
        sw_strobe = wr_ctrl && bus_req.wdata[CT_CLK] && (st.clock_source_select == CS_SOFT);
        tc_strobe = wr_ctrl && bus_req.wdata[CT_TC] && ext_src && st.clock_strobe_bit;
        shifted = {st.shift_data_bits[DATA_W-2:0], sdi_s};
        cnt_plus = st.edge_counter_value + CNT_ONE;
        collision = st.shift_data_bits[DATA_W-1] != sdi_s;

        // Clock source selection for shift register and counter
        case (st.clock_source_select)
            CS_SOFT: begin
                shift_clk = sw_strobe;
                cnt_clk = sw_strobe;
            end
            CS_TIMER: begin
                shift_clk = timer_match;
                cnt_clk = timer_match;
            end
            CS_EXT_POS: begin
                shift_clk = st.clock_strobe_bit ? tc_strobe : ext_rise;
                cnt_clk = st.clock_strobe_bit ? tc_strobe : ext_edge;
            end
            default: begin
                shift_clk = st.clock_strobe_bit ? tc_strobe : ext_fall;
                cnt_clk = st.clock_strobe_bit ? tc_strobe : ext_edge;
            end
        endcase

        // Counter; a CPU write takes priority over a count
        ovf_event = cnt_clk && !wr_status && (st.edge_counter_value == CNT_MAX);
        if (wr_status) begin
            next_st.edge_counter_value = bus_req.wdata[ST_CNT_HI:0];
        end else if (cnt_clk) begin
            next_st.edge_counter_value = cnt_plus;
        end

        // Shift register
        if (wr_data) begin
            next_st.shift_data_bits = bus_req.wdata;
        end else if (shift_clk) begin
            next_st.shift_data_bits = shifted;
        end
        if (ovf_event) begin
            next_st.received_byte_buffer = next_st.shift_data_bits;
        end

        // Output latch: open half of the external clock so output moves on the non-sampling edge
        if (!next_st.clock_source_select[1]) begin
            latch_open = 1'b1;
        end else if (next_st.clock_source_select == CS_EXT_POS) begin
            latch_open = !sck_s;
        end else begin
            latch_open = sck_s;
        end
        if (latch_open) begin
            next_st.out_latch = next_st.shift_data_bits[DATA_W-1];
        end

        // Control register
        if (wr_ctrl) begin
            next_st.start_interrupt_enable = bus_req.wdata[CT_SIE];
            next_st.overflow_interrupt_enable = bus_req.wdata[CT_OIE];
            next_st.wire_mode_select = bus_req.wdata[CT_WM_HI:CT_WM_LO];
            next_st.clock_source_select = bus_req.wdata[CT_CS_HI:CT_CS_LO];
            next_st.clock_strobe_bit = bus_req.wdata[CT_CLK];
            if (bus_req.wdata[CT_TC]) begin
                next_st.clock_port = !st.clock_port;
            end
        end

        // Start flag: sets beat a simultaneous clear
        next_st.det_prev = det_s;
        next_st.det_clear = wr_status && bus_req.wdata[ST_START];
        next_st.det_enable = next_st.wire_mode_select[1];
        if (two_wire && det_s && !st.det_prev) begin
            next_st.start_flag = 1'b1;
        end else if (!two_wire && ext_src && !st.clock_strobe_bit && ext_edge) begin
            next_st.start_flag = 1'b1;
        end else if (wr_status && bus_req.wdata[ST_START]) begin
            next_st.start_flag = 1'b0;
        end

        // Start hold begins at the SCL falling edge after the start
        if (wr_status && bus_req.wdata[ST_START]) begin
            next_st.hold_start = 1'b0;
        end else if (two_wire && st.start_flag && ext_fall) begin
            next_st.hold_start = 1'b1;
        end

        // Overflow flag and its hold
        if (ovf_event) begin
            next_st.overflow_flag = 1'b1;
        end else if (wr_status && bus_req.wdata[ST_OVF]) begin
            next_st.overflow_flag = 1'b0;
        end
        if (ovf_event && st.wire_mode_select == WM_TWO_HOLD) begin
            next_st.hold_ovf = 1'b1;
        end else if (wr_status && bus_req.wdata[ST_OVF]) begin
            next_st.hold_ovf = 1'b0;
        end

        // Stop flag: SDA rising while SCL high; no interrupt path
        next_st.sdi_prev = sdi_s;
        next_st.sck_prev = sck_s;
        if (two_wire && sdi_s && !st.sdi_prev && sck_s) begin
            next_st.stop_flag = 1'b1;
        end else if (wr_status && bus_req.wdata[ST_STOP]) begin
            next_st.stop_flag = 1'b0;
        end

        // Interrupt requests and wake-ups
        next_st.start_irq = next_st.start_flag && next_st.start_interrupt_enable && global_int_enable;
        next_st.overflow_irq = next_st.overflow_flag && next_st.overflow_interrupt_enable
                               && global_int_enable;
        next_st.overflow_wake = next_st.overflow_irq && sleep_is_idle;

        // Pins; direction bits gate every driver
        if (next_st.wire_mode_select[1]) begin
            next_st.pins.data_out = 1'b0;
            next_st.pins.data_oe = data_dir_out && !next_st.out_latch;
            next_st.pins.clk_out = 1'b0;
            next_st.pins.clk_oe = clock_dir_out && (!next_st.clock_port || next_st.hold_start
                                  || next_st.hold_ovf);
        end else begin
            next_st.pins.data_out = next_st.out_latch;
            next_st.pins.data_oe = data_dir_out && (next_st.wire_mode_select == WM_THREE);
            next_st.pins.clk_out = next_st.clock_port;
            next_st.pins.clk_oe = clock_dir_out;
        end

        // Read data valid only in the cycle after the strobe
        next_st.rdata = READ_ZERO;
        if (bus_req.rd) begin
            if (bus_req.addr == OFF_SHIFT_DATA) begin
                next_st.rdata = st.shift_data_bits;
            end else if (bus_req.addr == OFF_RX_BUFFER) begin
                next_st.rdata = st.received_byte_buffer;
            end else if (bus_req.addr == OFF_STATUS) begin
                next_st.rdata = status_word(st, collision);
            end else begin
                next_st.rdata = control_word(st);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.clock_port <= 1'b1;
            st.shift_data_bits <= DATA_RESET;
            st.received_byte_buffer <= DATA_RESET;
            st.edge_counter_value <= CNT_RESET;
            st.wire_mode_select <= FIELD2_RESET;
            st.clock_source_select <= FIELD2_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign pins = st.pins;
    assign start_irq = st.start_irq;
    assign overflow_irq = st.overflow_irq;
    assign overflow_wake = st.overflow_wake;
    assign start_wake = det_raw;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_WRITE_BEATS_SHIFT: assert property (wr_data |=> st.shift_data_bits == $past(bus_req.wdata))
        else $error("data write did not win over shift");
    AST_SHIFT_LEFT: assert property (!wr_data && shift_clk |=> st.shift_data_bits == $past(shifted))
        else $error("shift register did not shift left");
    AST_COUNT_BOTH_EDGES: assert property (ext_src && !st.clock_strobe_bit && ext_edge && !wr_status
        |=> st.edge_counter_value == $past(cnt_plus))
        else $error("external edge did not count");
    AST_OVF_SET: assert property (ovf_event |=> st.overflow_flag && st.edge_counter_value == CNT_RESET)
        else $error("wrap did not set overflow flag");
    AST_OVF_STICKY: assert property (st.overflow_flag && !(wr_status && bus_req.wdata[ST_OVF])
        |=> st.overflow_flag)
        else $error("overflow flag cleared without write");
    AST_BUFFER_COPY: assert property (ovf_event |=> st.received_byte_buffer == st.shift_data_bits)
        else $error("buffer not loaded on transfer end");
    AST_DET_OFF: assert property (!next_st.wire_mode_select[1] |=> !st.det_enable)
        else $error("start detector enabled outside two-wire");
    // A clear of the flag or of its enable in the same cycle legally drops the request
    AST_START_IRQ: assert property (st.start_flag && st.start_interrupt_enable && global_int_enable
        && !(wr_status && bus_req.wdata[ST_START]) && !(wr_ctrl && !bus_req.wdata[CT_SIE])
        |=> st.start_irq)
        else $error("start interrupt not raised");
    AST_IDLE_ONLY: assert property (!sleep_is_idle |=> !st.overflow_wake)
        else $error("overflow wake outside idle");
    AST_LATCH_OPEN: assert property (!st.clock_source_select[1] && !wr_ctrl
        |=> st.out_latch == st.shift_data_bits[DATA_W-1])
        else $error("latch not transparent for internal clock");
endmodule

// File: hdl/sus_pkg.sv
// Shared constants and carrier types for the serial shift unit
package sus_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_SHIFT_DATA = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_RX_BUFFER = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 2'h2;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 2'h3;

    // Status register fields
    localparam int ST_START = 7;
    localparam int ST_OVF = 6;
    localparam int ST_STOP = 5;
    localparam int ST_COLL = 4;
    localparam int ST_CNT_HI = 3;

    // Control register fields
    localparam int CT_SIE = 7;
    localparam int CT_OIE = 6;
    localparam int CT_WM_HI = 5;
    localparam int CT_WM_LO = 4;
    localparam int CT_CS_HI = 3;
    localparam int CT_CS_LO = 2;
    localparam int CT_CLK = 1;
    localparam int CT_TC = 0;

    // Wire modes
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;

    // Clock sources
    localparam logic [1:0] CS_SOFT = 2'h0;
    localparam logic [1:0] CS_TIMER = 2'h1;
    localparam logic [1:0] CS_EXT_POS = 2'h2;
    localparam logic [1:0] CS_EXT_NEG = 2'h3;

    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [1:0] FIELD2_RESET = 2'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sus_bus_req_type;

    typedef struct packed {
        logic data_out;
        logic data_oe;
        logic clk_out;
        logic clk_oe;
    } sus_pin_out_type;
endpackage

// File: hdl/sus_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sus_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// File: hdl/sus_start_detect.sv
// Clockless start condition catcher on the two-wire lines
`timescale 1ns/1ps
module sus_start_detect (
    // Reset and control from the register side
    input wire logic reset,
    input wire logic enable,
    input wire logic clear,
    // Bus lines
    input wire logic sda_in,
    input wire logic scl_in,
    // Result
    output logic detected
);
    logic kill;

    // Held cleared outside two-wire mode and for one cycle after software writes one to the start flag
    assign kill = reset | clear | ~enable;

    // SDA falling while SCL high; needs no system clock so it can wake a stopped core
    always_ff @(negedge sda_in or posedge kill) begin
        if (kill) begin
            detected <= 1'b0;
        end else if (scl_in) begin
            detected <= 1'b1;
        end
    end
endmodule

// File: dv/sus_far_end.sv
// Far-end model: serial bus master driving the clock and data pins
`timescale 1ns/1ps
module sus_far_end
    import sus_pkg::*;
(
    // Mode and device pin drive
    input wire logic two_wire,
    input wire sus_pin_out_type pins,
    // Resolved pin levels
    output logic serial_data_in,
    output logic serial_clock_pin
);
    logic sda = 1'b1;
    logic scl = 1'b0;

    // Open-drain in two-wire mode: a device enable pulls the line low
    assign serial_data_in = two_wire ? (sda & ~pins.data_oe) : sda;
    assign serial_clock_pin = two_wire ? (scl & ~pins.clk_oe) : scl;

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sda = tx[i];
            #32;
            rx[i] = pins.data_out;
            scl = 1'b1;
            #32;
            scl = 1'b0;
        end
        #32;
        // Released line must not keep showing the last bit
        sda = ~sda;
    endtask

    task automatic start_cond();
        sda = 1'b1;
        scl = 1'b1;
        #32;
        sda = 1'b0;
        #32;
        scl = 1'b0;
        #32;
    endtask

    task automatic stop_cond();
        sda = 1'b0;
        #32;
        scl = 1'b1;
        #32;
        sda = 1'b1;
        #32;
    endtask
endmodule

// File: dv/sus_core_tb.sv
// Self-checking bench for the serial shift unit core
`timescale 1ns/1ps
module sus_core_tb;
    import sus_pkg::*;
    logic clk, reset, sdi, sck, dd, cd, tm, gie, idle, two_wire;
    logic sirq, oirq, owake, swake;
    logic [7:0] rdata, s, rx;
    sus_bus_req_type bus_req;
    sus_pin_out_type pins;
    int failures = 0;
    int n_checks = 0;

    sus_core dut (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
        .serial_data_in(sdi), .serial_clock_pin(sck), .pins(pins), .data_dir_out(dd),
        .clock_dir_out(cd), .timer_match(tm), .global_int_enable(gie), .sleep_is_idle(idle),
        .start_irq(sirq), .overflow_irq(oirq), .overflow_wake(owake), .start_wake(swake));
    sus_far_end far (.two_wire(two_wire), .pins(pins), .serial_data_in(sdi), .serial_clock_pin(sck));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chkr(input logic [1:0] a, input logic [7:0] exp);
        rd(a, s);
        chk(s, exp);
    endtask

    // Collision bit follows the live pin, so it is masked here
    task automatic chks(input logic [7:0] exp);
        rd(OFF_STATUS, s);
        chk(s & 8'hef, exp);
    endtask

    task automatic pulse_timer();
        @(posedge clk);
        tm <= 1'b1;
        @(posedge clk);
        tm <= 1'b0;
    endtask

    task automatic t_reset();
        chkr(OFF_SHIFT_DATA, 8'h00);
        chkr(OFF_RX_BUFFER, 8'h00);
        chks(8'h00);
        chkr(OFF_CONTROL, 8'h00);
    endtask

    task automatic t_soft();
        wr(OFF_CONTROL, 8'h10);
        wr(OFF_SHIFT_DATA, 8'h85);
        tick(6);
        chk(pins.data_out, 1'b1);
        chk(pins.data_oe, 1'b1);
        wr(OFF_CONTROL, 8'h12);
        tick(4);
        chkr(OFF_SHIFT_DATA, 8'h0b);
        chks(8'h01);
        chk(pins.data_out, 1'b0);
        wr(OFF_STATUS, 8'h07);
        chks(8'h07);
    endtask

    task automatic t_timer();
        wr(OFF_CONTROL, 8'h54);
        far.sda = 1'b0;
        wr(OFF_SHIFT_DATA, 8'h81);
        wr(OFF_STATUS, 8'h0f);
        tick(4);
        pulse_timer();
        tick(2);
        chks(8'h40);
        chkr(OFF_RX_BUFFER, 8'h02);
        chk(oirq, 1'b1);
        chk(owake, 1'b0);
        idle <= 1'b1;
        tick(3);
        chk(owake, 1'b1);
        idle <= 1'b0;
        pulse_timer();
        tick(2);
        chks(8'h41);
        wr(OFF_STATUS, 8'h01);
        chks(8'h41);
        wr(OFF_STATUS, 8'h40);
        tick(2);
        chks(8'h00);
        chk(oirq, 1'b0);
        // Data write and timer clock land on the same edge
        @(posedge clk);
        bus_req <= '{addr: OFF_SHIFT_DATA, wdata: 8'h3c, wr: 1'b1, rd: 1'b0};
        tm <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        tm <= 1'b0;
        chkr(OFF_SHIFT_DATA, 8'h3c);
    endtask

    task automatic t_spi();
        wr(OFF_CONTROL, 8'h18);
        wr(OFF_STATUS, 8'he0);
        wr(OFF_SHIFT_DATA, 8'hc5);
        far.xfer(8'h3c, rx);
        tick(8);
        chk(rx, 8'hc5);
        chkr(OFF_SHIFT_DATA, 8'h3c);
        chkr(OFF_RX_BUFFER, 8'h3c);
        chks(8'hc0);
        wr(OFF_CONTROL, 8'h5c);
        wr(OFF_STATUS, 8'hcf);
        far.scl = 1'b1;
        tick(8);
        chk(oirq, 1'b1);
        rd(OFF_STATUS, s);
        chk(s & 8'h4f, 8'h40);
        far.scl = 1'b0;
        tick(8);
    endtask

    task automatic t_toggle();
        wr(OFF_CONTROL, 8'h1a);
        wr(OFF_STATUS, 8'he0);
        far.scl = 1'b1;
        tick(8);
        far.scl = 1'b0;
        tick(8);
        chks(8'h00);
        wr(OFF_CONTROL, 8'h1b);
        tick(2);
        chks(8'h01);
        chk(pins.clk_out, 1'b0);
        // Second toggle puts the clock port back high so the three-wire clock output drives high again
        wr(OFF_CONTROL, 8'h1b);
        tick(2);
        chks(8'h02);
        chk(pins.clk_out, 1'b1);
    endtask

    task automatic t_two_wire();
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_STATUS, 8'he0);
        far.start_cond();
        tick(8);
        chks(8'h00);
        chk(swake, 1'b0);
        wr(OFF_CONTROL, 8'h28);
        two_wire <= 1'b1;
        wr(OFF_STATUS, 8'he0);
        far.start_cond();
        chk(swake, 1'b1);
        tick(8);
        rd(OFF_STATUS, s);
        chk(s[7], 1'b1);
        chk(sirq, 1'b0);
        chk(pins.clk_oe, 1'b1);
        wr(OFF_CONTROL, 8'ha8);
        tick(2);
        chk(sirq, 1'b1);
        // Lines rising together above may already have flagged a stop; clear it too
        wr(OFF_STATUS, 8'ha0);
        tick(4);
        chk(pins.clk_oe, 1'b0);
        chk(sirq, 1'b0);
        rd(OFF_STATUS, s);
        chk(s[5], 1'b0);
        far.stop_cond();
        tick(8);
        rd(OFF_STATUS, s);
        chk(s[5], 1'b1);
        chk({sirq, oirq}, 2'b00);
        far.scl = 1'b0;
        wr(OFF_SHIFT_DATA, 8'h80);
        tick(8);
        far.sda = 1'b0;
        tick(8);
        rd(OFF_STATUS, s);
        chk(s[4], 1'b1);
        far.sda = 1'b1;
        tick(8);
        rd(OFF_STATUS, s);
        chk(s[4], 1'b0);
        far.scl = 1'b1;
        wr(OFF_CONTROL, 8'h38);
        wr(OFF_STATUS, 8'hef);
        far.scl = 1'b0;
        tick(8);
        chk(pins.clk_oe, 1'b1);
        wr(OFF_STATUS, 8'h40);
        tick(4);
        chk(pins.clk_oe, 1'b0);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        end_sim();
    end

    initial begin
        bus_req = '0;
        dd = 1'b1;
        cd = 1'b1;
        tm = 1'b0;
        gie = 1'b1;
        idle = 1'b0;
        two_wire = 1'b0;
        reset = 1'b1;
        tick(5);
        reset <= 1'b0;
        tick(3);
        t_reset();
        t_soft();
        t_timer();
        t_spi();
        t_toggle();
        t_two_wire();
        end_sim();
    end
endmodule
